// File: core_pin_slot.sv
// Purpose: one core's stage in the wired-or pin chain
// Assumes: all inputs come from logic on the system clock
// Notes:   purely combinational; the combiner registers the chain end
module core_pin_slot
    import shared_pin_pkg::*;
(
    input  wire logic             run,
    input  wire logic [PIN_W-1:0] dir_reg,
    input  wire logic [PIN_W-1:0] out_reg,
    input  wire logic [PIN_W-1:0] ctr_a,
    input  wire logic [PIN_W-1:0] ctr_b,
    input  wire pin_drive_t       chain_in,
    output pin_drive_t            chain_out
);

    logic [PIN_W-1:0] own_dir;
    logic [PIN_W-1:0] own_lvl;

    // a stopped core contributes nothing, whatever its registers hold
    assign own_dir = dir_reg & {PIN_W{run}};
    // counter outputs join the output register, then the direction mask
    assign own_lvl = (out_reg | ctr_a | ctr_b) & own_dir;

    // or onto what the earlier cores already drive
    assign chain_out.dir = chain_in.dir | own_dir;
    assign chain_out.lvl = chain_in.lvl | own_lvl;

endmodule

// File: pin_world.sv
// Purpose: external circuit on the shared pins, seen from the pad side
// Assumes: pads with output enable high are driven by the chip
// Notes:   undriven pads follow the external source, which the bench drives
module pin_world
    import shared_pin_pkg::*;
(
    input  wire logic [PIN_W-1:0] pin_out,
    input  wire logic [PIN_W-1:0] pin_oe,
    input  wire logic [PIN_W-1:0] ext_lvl,
    output logic      [PIN_W-1:0] pin_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // a driven pad shows the chip level, no contention with the outside
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
endmodule

// File: shared_pin_pkg.sv
// Purpose: shared constants, register map and carrier types for the shared pin combiner
// Assumes: 32-bit APB data, one aligned word per register, one system clock
// Notes:   each core owns a 16-byte window of four registers
package shared_pin_pkg;

    localparam int PIN_W       = 32;      // one bit per shared pin
    localparam int CORE_N      = 8;       // documented core count
    localparam int ADDR_W      = 8;       // apb byte address width
    localparam int CORE_STRIDE = 16;      // bytes per core window
    localparam int CORE_LSB    = 4;       // core index field in paddr
    localparam int CORE_IDX_W  = 3;
    localparam int SEL_LSB     = 2;       // register select field in paddr
    localparam int SEL_W       = 2;

    // register select within a core window (byte offset = select * 4)
    localparam logic [SEL_W-1:0] SEL_DIR  = 2'h0;  // pin_direction, rw
    localparam logic [SEL_W-1:0] SEL_OUT  = 2'h1;  // pin_output, rw
    localparam logic [SEL_W-1:0] SEL_IN   = 2'h2;  // pin_input, ro
    localparam logic [SEL_W-1:0] SEL_CTRL = 2'h3;  // core_control, rw

    localparam int CTRL_RUN_BIT = 0;      // core_control: 1 = core active

    // reset values
    localparam logic [PIN_W-1:0] DIR_RESET = 32'h0000_0000;
    localparam logic [PIN_W-1:0] OUT_RESET = 32'h0000_0000;
    localparam logic             RUN_RESET = 1'b0;

    // pins owned by the startup sequence until it completes
    localparam int BOOT_PIN_LO = 28;
    localparam int BOOT_PIN_N  = 4;

    typedef struct packed {
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [PIN_W-1:0]  pwdata;
    } apb_req_t;

    typedef struct packed {
        logic [PIN_W-1:0] prdata;
        logic             pready;
        logic             pslverr;
    } apb_rsp_t;

    // direction and level of all pins, passed core to core
    typedef struct packed {
        logic [PIN_W-1:0] dir;
        logic [PIN_W-1:0] lvl;
    } pin_drive_t;

endpackage

// File: shared_pin_wired_or.sv
// Purpose: wired-or combiner of per-core direction and output onto 32 shared pins
// Assumes: apb slave with zero wait states; pin inputs are asynchronous
// Notes:   pins settle one clock after the register write that moves them
//
// Notes on behaviour
// - every core has its own 32-bit direction and output register
// - pin direction is the or of all cores' directions, chained core by core
// - core contribution is output register or counter outputs, masked by its direction
// - pin level is the or of all masked contributions
// - a pin stays an input unless some active core, or startup on pins 28 to 31, sets its direction bit
// - stopping a core clears its direction and output to zero
// - input register read returns the live pin levels, whatever the direction
// - direction bit one makes the pin an output, zero an input
// - pins 28 to 31 belong to startup, then become ordinary pins
// - the combiner takes one to eight identical cores (NUM_CORES, eight by default), numbered from zero
// - counter outputs reach a pin only where that core's direction bit is set
module shared_pin_wired_or
    import shared_pin_pkg::*;
#(
    parameter int NUM_CORES = CORE_N
)
(
    input  wire logic                            pclk,
    input  wire logic                            presetn,
    input  wire apb_req_t                        apb_req,
    output apb_rsp_t                             apb_rsp,
    input  wire logic [NUM_CORES-1:0][PIN_W-1:0] counter_module_a_src,
    input  wire logic [NUM_CORES-1:0][PIN_W-1:0] counter_module_b_src,
    input  wire logic                            boot_active,
    input  wire logic [BOOT_PIN_N-1:0]           boot_dir,
    input  wire logic [BOOT_PIN_N-1:0]           boot_lvl,
    input  wire logic [PIN_W-1:0]                pin_in,
    output logic      [PIN_W-1:0]                pin_out,
    output logic      [PIN_W-1:0]                pin_oe
);

    // the address map holds a three-bit core index
    if (NUM_CORES < 1 || NUM_CORES > (1 << CORE_IDX_W))
    begin : g_core_check
        $error("NUM_CORES must lie between 1 and 8");
    end

    localparam logic [ADDR_W:0] MAP_LIMIT = (ADDR_W+1)'(NUM_CORES * CORE_STRIDE);

    typedef struct packed {
        logic [NUM_CORES-1:0][PIN_W-1:0] dir;
        logic [NUM_CORES-1:0][PIN_W-1:0] out;
        logic [NUM_CORES-1:0]            run;
        logic [PIN_W-1:0]                meta;
        logic [PIN_W-1:0]                sync;
        logic [PIN_W-1:0]                oe;
        logic [PIN_W-1:0]                lvl;
        logic [PIN_W-1:0]                rdata;
    } state_t;

    state_t                  state_reg;
    state_t                  state_next;
    pin_drive_t              chain [NUM_CORES+1];
    logic                    setup_ph;
    logic                    access_ph;
    logic                    mapped;
    logic [CORE_IDX_W-1:0]   core_idx;
    logic [SEL_W-1:0]        reg_sel;

    // address decode shared by read capture and write
    assign setup_ph  = apb_req.psel & ~apb_req.penable;
    assign access_ph = apb_req.psel & apb_req.penable;
    assign mapped    = {1'b0, apb_req.paddr} < MAP_LIMIT;
    assign core_idx  = apb_req.paddr[CORE_LSB +: CORE_IDX_W];
    assign reg_sel   = apb_req.paddr[SEL_LSB +: SEL_W];

    // one identical slot per core, chained from core zero upward
    assign chain[0] = '0;
    for (genvar c = 0; c < NUM_CORES; c++)
    begin : g_slot
        core_pin_slot u_slot (
            .run       (state_reg.run[c]),
            .dir_reg   (state_reg.dir[c]),
            .out_reg   (state_reg.out[c]),
            .ctr_a     (counter_module_a_src[c]),
            .ctr_b     (counter_module_b_src[c]),
            .chain_in  (chain[c]),
            .chain_out (chain[c+1])
        );
    end

    // next state: bus access, core stop, pin synchroniser and pin drive
    always_comb
    begin
        state_next = state_reg;
        // read data is captured in setup so it is steady through access
        if (setup_ph)
        begin
            state_next.rdata = '0;
            if (mapped)
            begin
                case (reg_sel)
                    SEL_DIR:  state_next.rdata = state_reg.dir[core_idx];
                    SEL_OUT:  state_next.rdata = state_reg.out[core_idx];
                    SEL_IN:   state_next.rdata = state_reg.sync;
                    SEL_CTRL: state_next.rdata = {{(PIN_W-1){1'b0}}, state_reg.run[core_idx]};
                    default:  state_next.rdata = '0;
                endcase
            end
        end
        // writes take effect at the access edge; input register ignores them
        if (access_ph && apb_req.pwrite && mapped)
        begin
            case (reg_sel)
                SEL_DIR:  state_next.dir[core_idx] = apb_req.pwdata;
                SEL_OUT:  state_next.out[core_idx] = apb_req.pwdata;
                SEL_CTRL: state_next.run[core_idx] = apb_req.pwdata[CTRL_RUN_BIT];
                default:  state_next.rdata = state_reg.rdata;
            endcase
        end
        // a stopped core holds zeros, so a restart never revives old drive
        for (int c = 0; c < NUM_CORES; c++)
        begin
            if (!state_next.run[c])
            begin
                state_next.dir[c] = DIR_RESET;
                state_next.out[c] = OUT_RESET;
            end
        end
        // two flops before anyone looks at the pins
        state_next.meta = pin_in;
        state_next.sync = state_reg.meta;
        // registered end of the chain drives the pads
        state_next.oe  = chain[NUM_CORES].dir;
        state_next.lvl = chain[NUM_CORES].lvl;
        // startup owns the top pins until it lets go
        if (boot_active)
        begin
            state_next.oe[BOOT_PIN_LO +: BOOT_PIN_N]  = boot_dir;
            state_next.lvl[BOOT_PIN_LO +: BOOT_PIN_N] = boot_lvl & boot_dir;
        end
    end

    // the whole state in one register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_reg.dir   <= {NUM_CORES{DIR_RESET}};
            state_reg.out   <= {NUM_CORES{OUT_RESET}};
            state_reg.run   <= {NUM_CORES{RUN_RESET}};
            state_reg.meta  <= '0;
            state_reg.sync  <= '0;
            state_reg.oe    <= '0;
            state_reg.lvl   <= '0;
            state_reg.rdata <= '0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // zero wait states; unmapped addresses answer with an error and zero data
    assign apb_rsp.pready  = 1'b1;
    assign apb_rsp.pslverr = access_ph & ~mapped;
    assign apb_rsp.prdata  = state_reg.rdata;
    assign pin_oe          = state_reg.oe;
    assign pin_out         = state_reg.lvl;

    // reference or of all active cores, kept apart from the slot chain
    logic [PIN_W-1:0]     ref_dir;
    logic [PIN_W-1:0]     ref_lvl;
    logic [PIN_W-1:0]     boot_mask;
    logic [NUM_CORES-1:0] stop_dirty;   // drive still held by a stopped core
    always_comb
    begin
        ref_dir = '0;
        ref_lvl = '0;
        stop_dirty = '0;
        for (int c = 0; c < NUM_CORES; c++)
        begin
            stop_dirty[c] = !state_reg.run[c] &&
                            ((state_reg.dir[c] | state_reg.out[c]) != '0);
            if (state_reg.run[c])
            begin
                ref_dir = ref_dir | state_reg.dir[c];
                ref_lvl = ref_lvl | (state_reg.dir[c] &
                          (state_reg.out[c] | counter_module_a_src[c] |
                           counter_module_b_src[c]));
            end
        end
        boot_mask = '1;
        if (boot_active)
        begin
            boot_mask[BOOT_PIN_LO +: BOOT_PIN_N] = '0;
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // a write to a running core's direction lands at the access edge
    dir_write_a: assert property (
        access_ph && apb_req.pwrite && mapped && reg_sel == SEL_DIR &&
        state_reg.run[core_idx] |=>
        state_reg.dir[$past(core_idx)] == $past(apb_req.pwdata))
        else $error("direction write lost");

    dir_or_a: assert property (
        ##1 ((pin_oe & $past(boot_mask)) == ($past(ref_dir) & $past(boot_mask))))
        else $error("pin direction is not the or of core directions");

    masked_level_a: assert property (
        (pin_out & ~pin_oe) == '0)
        else $error("pin level driven without direction");

    level_or_a: assert property (
        ##1 ((pin_out & $past(boot_mask)) == ($past(ref_lvl) & $past(boot_mask))))
        else $error("pin level is not the or of contributions");

    idle_input_a: assert property (
        !boot_active && state_reg.run == '0 |=> pin_oe == '0)
        else $error("pin driven with no active core");

    stop_clears_a: assert property (
        $changed(state_reg.run) |-> stop_dirty == '0
        ##1 (pin_oe[BOOT_PIN_LO-1:0] & ~$past(ref_dir[BOOT_PIN_LO-1:0])) == '0)
        else $error("stopped core still holds drive");

    input_read_a: assert property (
        setup_ph && mapped && reg_sel == SEL_IN |=>
        apb_rsp.prdata == $past(pin_in, 3))
        else $error("input read does not show pin levels");

    boot_release_a: assert property (
        $fell(boot_active) |=>
        pin_oe[BOOT_PIN_LO +: BOOT_PIN_N] == $past(ref_dir[BOOT_PIN_LO +: BOOT_PIN_N]))
        else $error("top pins not released after startup");

    last_core_a: assert property (
        state_reg.run[NUM_CORES-1] && !boot_active |=>
        (pin_oe & $past(state_reg.dir[NUM_CORES-1])) == $past(state_reg.dir[NUM_CORES-1]))
        else $error("last core cannot reach the pins");

    counter_gate_a: assert property (
        ref_dir == '0 && !boot_active |=> pin_out == '0)
        else $error("counter output leaks without direction");

    reset_clear_a: assert property (
        $past(presetn) == 1'b0 |-> pin_oe == '0 && state_reg.run == '0)
        else $error("state not cleared by reset");

    // bus side: what reads show and what writes may not touch
    dir_read_a: assert property (
        setup_ph && mapped && reg_sel == SEL_DIR |=>
        apb_rsp.prdata == $past(state_reg.dir[core_idx]))
        else $error("direction read does not show the register");

    ctrl_read_a: assert property (
        setup_ph && mapped && reg_sel == SEL_CTRL |=>
        apb_rsp.prdata == PIN_W'($past(state_reg.run[core_idx])))
        else $error("control read does not show the run bit");

    run_write_a: assert property (
        access_ph && apb_req.pwrite && mapped && reg_sel == SEL_CTRL |=>
        state_reg.run[$past(core_idx)] == $past(apb_req.pwdata[CTRL_RUN_BIT]))
        else $error("run bit write lost");

    // a stopped core refuses drive, so the write must leave zero behind
    stopped_write_a: assert property (
        access_ph && apb_req.pwrite && mapped && reg_sel == SEL_DIR &&
        !state_reg.run[core_idx] |=> state_reg.dir[$past(core_idx)] == '0)
        else $error("stopped core took a direction write");

    input_ro_a: assert property (
        access_ph && apb_req.pwrite && mapped && reg_sel == SEL_IN |=>
        $stable(state_reg.dir) && $stable(state_reg.out) && $stable(state_reg.run))
        else $error("input register write changed core state");

    unmapped_write_a: assert property (
        access_ph && apb_req.pwrite && !mapped |=>
        $stable(state_reg.dir) && $stable(state_reg.out) && $stable(state_reg.run))
        else $error("unmapped write changed core state");

    // startup owns the top pins one edge after it asks
    boot_own_a: assert property (
        boot_active |=>
        pin_oe[BOOT_PIN_LO +: BOOT_PIN_N] == $past(boot_dir) &&
        pin_out[BOOT_PIN_LO +: BOOT_PIN_N] == $past(boot_lvl & boot_dir))
        else $error("startup does not own the top pins");

    shared_pin_c: cover property (
        state_reg.run[0] && state_reg.run[1] && (state_reg.dir[0] & state_reg.dir[1]) != '0);
    core_stop_c:  cover property (($past(state_reg.run) & ~state_reg.run) != '0);
    input_read_c: cover property (setup_ph && mapped && reg_sel == SEL_IN);
    boot_free_c:  cover property ($fell(boot_active));
    bad_addr_c:   cover property (apb_rsp.pslverr);

endmodule

// File: tb_top.sv
// Purpose: self-checking bench for the shared pin combiner
// Assumes: zero wait apb slave, pins move one edge after a write
// Notes:   each scenario task drives the block and judges the result
module tb_top
    import shared_pin_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic                         pclk;
    logic                         presetn;
    apb_req_t                     req;
    apb_rsp_t                     rsp;
    logic [CORE_N-1:0][PIN_W-1:0] counter_module_a;
    logic [CORE_N-1:0][PIN_W-1:0] counter_module_b;
    logic                         boot_active;
    logic [3:0]                   boot_dir;
    logic [3:0]                   boot_lvl;
    logic [31:0]                  pin_in;
    logic [31:0]                  pin_out;
    logic [31:0]                  pin_oe;
    logic [31:0]                  ext_lvl;
    logic [31:0]                  rv;
    logic                         er;
    int                           mismatches;
    int                           checks_done;
    shared_pin_wired_or #(.NUM_CORES(CORE_N)) u_dut (
        .pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
        .counter_module_a_src(counter_module_a), .counter_module_b_src(counter_module_b),
        .boot_active(boot_active), .boot_dir(boot_dir), .boot_lvl(boot_lvl),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));
    pin_world u_world (.pin_out(pin_out), .pin_oe(pin_oe), .ext_lvl(ext_lvl), .pin_in(pin_in));
    // clock at 40 MHz
    initial
    begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    task test_done();
        if (mismatches == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp)
        begin
            $display("BAD %s exp %h seen %h", nm, exp, got);
            mismatches++;
        end
    endtask
    // one apb transfer; held until pready is seen at a rising edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge pclk);
        req.penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (rsp.pready !== 1'b1 && n < 50);
        if (rsp.pready !== 1'b1)
        begin
            mismatches++;
            test_done();
        end
        rv = rsp.prdata;
        er = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask
    task wr(input logic [3:0] c, input logic [1:0] s, input logic [31:0] d);
        apb(1'b1, {c, s, 2'h0}, d);
    endtask
    task rd(input logic [3:0] c, input logic [1:0] s);
        apb(1'b0, {c, s, 2'h0}, 32'h0000_0000);
    endtask
    // pins follow registers one edge after the write edge
    task settle();
        repeat (2) @(posedge pclk);
        #1;
    endtask
    task t_reset();
        chk("oe at reset", 32'h0, pin_oe);
        chk("out at reset", 32'h0, pin_out);
        rd(4'h0, SEL_DIR);
        chk("dir at reset", DIR_RESET, rv);
        chk("mapped err", 32'h0, {31'h0, er});
        rd(4'h7, SEL_OUT);
        chk("out reg at reset", OUT_RESET, rv);
    endtask
    // a stopped core cannot take hold of any pin
    task t_stopped();
        wr(4'h1, SEL_DIR, 32'hffff_ffff);
        rd(4'h1, SEL_DIR);
        chk("stopped dir", 32'h0, rv);
        settle();
        chk("stopped oe", 32'h0, pin_oe);
    endtask
    // distinct values per core; outputs sit outside each core's direction
    task t_own();
        for (int n = 0; n < CORE_N; n++)
        begin
            wr(4'(n), SEL_CTRL, 32'h1);
            wr(4'(n), SEL_DIR, 32'h1 << n);
            wr(4'(n), SEL_OUT, 32'h100 << n);
        end
        for (int n = 0; n < CORE_N; n++)
        begin
            rd(4'(n), SEL_DIR);
            chk("own dir", 32'h1 << n, rv);
            rd(4'(n), SEL_OUT);
            chk("own out", 32'h100 << n, rv);
        end
        rd(4'h3, SEL_CTRL);
        chk("run bit", 32'h1, rv);
        settle();
        chk("own oe", 32'h0000_00ff, pin_oe);
        chk("masked out", 32'h0, pin_out);
    endtask
    // eight sharing cases on pin 12, bit n of each byte is core n
    task t_table();
        logic [7:0] dt [8];
        logic [7:0] ot [8];
        dt = '{8'h00, 8'h01, 8'h01, 8'h01, 8'h03, 8'hff, 8'hff, 8'hf7};
        ot = '{8'h00, 8'h00, 8'h01, 8'h02, 8'h02, 8'h0a, 8'h08, 8'h08};
        for (int e = 0; e < 8; e++)
        begin
            for (int n = 0; n < CORE_N; n++)
            begin
                wr(4'(n), SEL_DIR, {19'h0, dt[e][n], 12'h0});
                wr(4'(n), SEL_OUT, {19'h0, ot[e][n], 12'h0});
            end
            settle();
            chk("table oe", {19'h0, |dt[e], 12'h0}, pin_oe);
            chk("table lvl", {19'h0, |(dt[e] & ot[e]), 12'h0}, pin_out);
        end
    endtask
    // counter outputs are gated by direction
    task t_ctr();
        wr(4'h3, SEL_DIR, 32'h0);
        counter_module_a[2] <= 32'h0000_0020;
        counter_module_b[5] <= 32'h0000_0004;
        settle();
        chk("ctr no dir", 32'h0, pin_out);
        wr(4'h2, SEL_DIR, 32'h0000_0020);
        wr(4'h5, SEL_DIR, 32'h0000_0004);
        settle();
        chk("ctr lvl", 32'h0000_0024, pin_out);
    endtask
    // stopping core 5 removes only its share; pin 12 stays with the others
    task t_stop();
        wr(4'h5, SEL_CTRL, 32'h0);
        settle();
        chk("stop oe", 32'h0000_1020, pin_oe);
        chk("stop lvl", 32'h0000_0020, pin_out);
        rd(4'h5, SEL_DIR);
        chk("stop dir", 32'h0, rv);
        counter_module_a[2] <= 32'h0;
    endtask
    // live pad levels whatever the direction; pin 5 is driven low
    task t_input();
        ext_lvl <= 32'ha5a5_0f2f;
        repeat (5) @(posedge pclk);
        rd(4'h4, SEL_IN);
        chk("input", 32'ha5a5_0f0f, rv);
        wr(4'h4, SEL_IN, 32'h0);
        rd(4'h4, SEL_IN);
        chk("input ro", 32'ha5a5_0f0f, rv);
    endtask
    // startup owns 28..31, then they act as ordinary pins
    task t_boot();
        boot_active <= 1'b1;
        boot_dir <= 4'hb;
        boot_lvl <= 4'h7;
        wr(4'h0, SEL_DIR, 32'h4000_0000);
        settle();
        chk("boot oe", 32'hb000_1020, pin_oe);
        chk("boot lvl", 32'h3000_0000, pin_out);
        boot_active <= 1'b0;
        settle();
        chk("after boot oe", 32'h4000_1020, pin_oe);
        chk("after boot lvl", 32'h0, pin_out);
    endtask
    task t_unmapped();
        wr(4'h8, SEL_DIR, 32'hffff_ffff);
        chk("unmapped wr err", 32'h1, {31'h0, er});
        rd(4'h8, SEL_DIR);
        chk("unmapped err", 32'h1, {31'h0, er});
        chk("unmapped data", 32'h0, rv);
    endtask
    // reset in mid-run stops every core; counter b of core 5 is still live
    task t_rerst();
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        #1;
        chk("oe after rerst", 32'h0, pin_oe);
        rd(4'h0, SEL_CTRL);
        chk("run after rerst", 32'h0, rv);
        rd(4'h2, SEL_DIR);
        chk("dir after rerst", DIR_RESET, rv);
        chk("ctr after rerst", 32'h0, pin_out);
    endtask
    // watchdog against any hang
    initial
    begin
        #2_000_000;
        mismatches++;
        test_done();
    end
    initial
    begin
        mismatches = 0;
        checks_done = 0;
        presetn = 1'b0;
        req = '0;
        counter_module_a = '0;
        counter_module_b = '0;
        boot_active = 1'b0;
        boot_dir = 4'h0;
        boot_lvl = 4'h0;
        ext_lvl = 32'h0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        #1;
        t_reset();
        t_stopped();
        t_own();
        t_table();
        t_ctr();
        t_stop();
        t_input();
        t_boot();
        t_unmapped();
        t_rerst();
        test_done();
    end
endmodule
